//--- verilog/oss_pkg.sv
package oss_pkg;

  // Configuration word 2 width and field positions.
  localparam int CW_W      = 24;
  localparam int PMODE_LSB = 0;
  localparam int OSCIO_BIT = 5;
  localparam int CKSM_LSB  = 6;
  localparam int FNOSC_LSB = 8;

  // Initial select encodings.
  localparam logic [2:0] SEL_FRC     = 3'h0;
  localparam logic [2:0] SEL_FRC_PLL = 3'h1;
  localparam logic [2:0] SEL_PRI     = 3'h2;
  localparam logic [2:0] SEL_PRI_PLL = 3'h3;
  localparam logic [2:0] SEL_SEC     = 3'h4;
  localparam logic [2:0] SEL_LOW_POWER_INTERNAL_RC    = 3'h5;
  localparam logic [2:0] SEL_RSVD    = 3'h6;
  localparam logic [2:0] SEL_FRC_DIV = 3'h7;

  // Primary mode encodings.
  localparam logic [1:0] PM_EC  = 2'h0;
  localparam logic [1:0] PM_XT  = 2'h1;
  localparam logic [1:0] PM_HS  = 2'h2;
  localparam logic [1:0] PM_OFF = 2'h3;

  // Switch and monitor field values that enable each feature.
  localparam logic       SW_ON     = 1'b0;
  localparam logic [1:0] CKSM_FULL = 2'h0;

  // Bit index of each oscillator in the synchroniser vector.
  localparam int SRC_PRI  = 0;
  localparam int SRC_SEC  = 1;
  localparam int SRC_FRC  = 2;
  localparam int SRC_LOW_POWER_INTERNAL_RC = 3;

  // Register byte offsets.
  localparam int         ADR_W      = 4;
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_CTRL   = 4'h4;
  localparam logic [3:0] REG_CFG    = 4'h8;

  // Control register fields and reset values.
  localparam int         CT_SEL_LSB   = 0;
  localparam int         CT_SWREQ     = 8;
  localparam int         CT_DIV_LSB   = 16;
  localparam int         CT_PINV      = 24;
  localparam int         CT_PINOE     = 25;
  localparam int         DIV_W        = 3;
  localparam logic [2:0] CT_DIV_RESET = 3'h1;

  // Nominal frequencies in MHz.
  localparam logic [7:0] FRC_MHZ = 8'h08;
  localparam logic [7:0] PLL_MHZ = 8'h60;

  // Cycles without a source edge before the monitor gives up.
  localparam int FAIL_SAFE_CLOCK_MONITOR_WAIT = 64;

endpackage

//--- verilog/oss_osc_select.sv
// The placing of the registers and register access over Wishbone were chosen for this implementation.
module oss_osc_select #(
  parameter int DIV_W     = oss_pkg::DIV_W,
  parameter int FAIL_SAFE_CLOCK_MONITOR_WAIT = oss_pkg::FAIL_SAFE_CLOCK_MONITOR_WAIT
) (
  // Clock and power-on reset.
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  // Configuration word 2 and non power-on reset pulse.
  input  wire logic [oss_pkg::CW_W-1:0] cfg_word2_i,
  input  wire logic                     warm_reset_i,
  // Oscillator levels.
  input  wire logic                     primary_osc_i,
  input  wire logic                     secondary_osc_i,
  input  wire logic                     fast_internal_rc_i,
  input  wire logic                     low_power_internal_rc_i,
  // Clock outputs.
  output logic                          sys_clk_o,
  output logic                          instr_clk_o,
  output logic                          usb_clk_o,
  output logic                          pll_on_o,
  // Oscillator output pin.
  output logic                          osc_output_pin_o,
  output logic                          osc_output_pin_oe_o,
  // Wishbone slave.
  input  wire logic                     wb_cyc_i,
  input  wire logic                     wb_stb_i,
  input  wire logic                     wb_we_i,
  input  wire logic [oss_pkg::ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]               wb_sel_i,
  input  wire logic [31:0]              wb_dat_i,
  output logic [31:0]                   wb_dat_o,
  output logic                          wb_ack_o
);

  localparam int CNT_W = (1 << DIV_W) - 1;
  localparam int IW    = $clog2(FAIL_SAFE_CLOCK_MONITOR_WAIT + 1);
  localparam logic [IW-1:0] IDLE_MAX = IW'(FAIL_SAFE_CLOCK_MONITOR_WAIT - 1);

  logic [3:0]             src_meta_q;
  logic [3:0]             src_sync_q;
  logic                   load_q;
  logic [oss_pkg::CW_W-1:0] cfg_q;
  logic [2:0]             cur_sel_q;
  logic [2:0]             ctrl_sel_q;
  logic [DIV_W-1:0]       ctrl_div_q;
  logic                   pin_val_q;
  logic                   pin_oe_q;
  logic                   swreq_q;
  logic                   frc_prev_q;
  logic [CNT_W-1:0]       frc_cnt_q;
  logic                   sys_clk_q;
  logic                   instr_q;
  logic                   usb_q;
  logic                   pll_q;
  logic                   fail_q;
  logic [IW-1:0]          idle_q;
  logic                   osc_output_pin_q;
  logic                   osc_output_pin_oe_q;
  logic                   wb_ack_q;
  logic [31:0]            wb_dat_q;

  // Synchronised oscillator levels.
  wire pri_s  = src_sync_q[oss_pkg::SRC_PRI];
  wire sec_s  = src_sync_q[oss_pkg::SRC_SEC];
  wire frc_s  = src_sync_q[oss_pkg::SRC_FRC];
  wire low_power_internal_rc_s = src_sync_q[oss_pkg::SRC_LOW_POWER_INTERNAL_RC];

  // Configuration fields, taken straight from the word in the load cycle.
  wire [oss_pkg::CW_W-1:0] cfg_src = load_q ? cfg_word2_i : cfg_q;
  wire [1:0] cfg_pmode = cfg_src[oss_pkg::PMODE_LSB +: 2];
  wire [2:0] cfg_fnosc = cfg_src[oss_pkg::FNOSC_LSB +: 3];
  wire [1:0] cfg_cksm  = cfg_src[oss_pkg::CKSM_LSB +: 2];
  wire       cfg_oscio = cfg_src[oss_pkg::OSCIO_BIT];

  // Feature enables from the switch and monitor field.
  wire sw_en   = cfg_cksm[1] == oss_pkg::SW_ON;
  wire fail_safe_clock_monitor_en = cfg_cksm == oss_pkg::CKSM_FULL;

  // Reload causes and the wanted selection.
  wire swap_go = swreq_q & sw_en & ~load_q;
  wire warm_go = warm_reset_i & ~sw_en;
  wire fail_go;
  wire reload  = load_q | warm_go | swap_go | fail_go;
  wire [2:0] want_sel = swap_go ? ctrl_sel_q : cfg_fnosc;

  // Legal pairings of select and primary mode; the rest fall back.
  wire pm_off  = cfg_pmode == oss_pkg::PM_OFF;
  wire pll_ok  = (cfg_pmode == oss_pkg::PM_XT)
               | (cfg_pmode == oss_pkg::PM_EC);
  wire want_ok = (want_sel == oss_pkg::SEL_PRI)     ? ~pm_off
               : (want_sel == oss_pkg::SEL_PRI_PLL) ? pll_ok
               : (want_sel != oss_pkg::SEL_RSVD);
  wire [2:0] next_sel = fail_go ? oss_pkg::SEL_FRC
                      : want_ok ? want_sel
                      : oss_pkg::SEL_FRC_DIV;

  // Fast RC divider: bit k of the both-edge counter is the RC over 2**k.
  wire [DIV_W-1:0] div_idx = ctrl_div_q - DIV_W'(1);
  wire frc_div = (ctrl_div_q == '0) ? frc_s : frc_cnt_q[div_idx];

  // Source mux; exactly one source reaches the processor clock.
  wire is_pri  = (cur_sel_q == oss_pkg::SEL_PRI)
               | (cur_sel_q == oss_pkg::SEL_PRI_PLL);
  wire pll_use = (cur_sel_q == oss_pkg::SEL_PRI_PLL)
               | (cur_sel_q == oss_pkg::SEL_FRC_PLL);
  wire src_lvl = is_pri ? pri_s
               : (cur_sel_q == oss_pkg::SEL_SEC) ? sec_s
               : (cur_sel_q == oss_pkg::SEL_LOW_POWER_INTERNAL_RC) ? low_power_internal_rc_s
               : (cur_sel_q == oss_pkg::SEL_FRC_DIV) ? frc_div
               : frc_s;

  // Instruction clock toggles on each processor clock rise.
  wire src_rise = src_lvl & ~sys_clk_q;
  wire src_edge = src_lvl ^ sys_clk_q;
  wire instr_d  = instr_q ^ src_rise;

  // Monitor fires when the running source stops toggling, unless the select is SEL_FRC, the fast RC without PLL or divider.
  assign fail_go = fail_safe_clock_monitor_en & ~load_q & (idle_q == IDLE_MAX)
                 & (cur_sel_q != oss_pkg::SEL_FRC);

  // Output pin: free when primary is unused or external clock.
  wire pin_free = ~is_pri | (cfg_pmode == oss_pkg::PM_EC);
  wire pin_clk  = pin_free & cfg_oscio;
  wire osc_output_pin_d   = pin_clk ? instr_d : pin_val_q;
  wire osc_output_pin_oe_d = pin_clk | (pin_free & pin_oe_q);

  // Nominal processor clock frequency shown in status.
  wire [7:0] freq_mhz = pll_use ? oss_pkg::PLL_MHZ
    : (cur_sel_q == oss_pkg::SEL_FRC_DIV) ? (oss_pkg::FRC_MHZ >> ctrl_div_q)
    : (cur_sel_q == oss_pkg::SEL_FRC) ? oss_pkg::FRC_MHZ
    : 8'h00;

  // Bus decode.
  wire acc    = wb_cyc_i & wb_stb_i & ~wb_ack_q;
  wire hit_st = wb_adr_i == oss_pkg::REG_STATUS;
  wire hit_ct = wb_adr_i == oss_pkg::REG_CTRL;
  wire hit_cf = wb_adr_i == oss_pkg::REG_CFG;
  wire wr_ct  = acc & wb_we_i & hit_ct;
  wire [31:0] st_word = {8'h00, freq_mhz, 4'h0, fail_q, pll_q, fail_safe_clock_monitor_en,
                         sw_en, 2'h0, cfg_pmode, 1'b0, cur_sel_q};
  wire [31:0] ct_word = {6'h00, pin_oe_q, pin_val_q,
                         (8 - DIV_W)'(0), ctrl_div_q, 13'h0000, ctrl_sel_q};
  wire [31:0] rd_word = hit_st ? st_word
                      : hit_ct ? ct_word
                      : hit_cf ? 32'(cfg_q)
                      : 32'h0000_0000;

  // Two-stage synchroniser for the oscillator levels.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      src_meta_q <= 4'h0;
      src_sync_q <= 4'h0;
    end else begin
      src_meta_q <= {low_power_internal_rc_i, fast_internal_rc_i,
                     secondary_osc_i, primary_osc_i};
      src_sync_q <= src_meta_q;
    end
  end

  // Configuration is caught once, at the first edge after power-on.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      load_q <= 1'b1;
      cfg_q  <= '0;
    end else begin
      load_q <= 1'b0;
      if (load_q) begin
        cfg_q <= cfg_word2_i;
      end
    end
  end

  // Current source; a warm reset keeps it while switching is enabled.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cur_sel_q <= oss_pkg::SEL_FRC_DIV;
    end else if (reload) begin
      cur_sel_q <= next_sel;
    end
  end

  // Control register with per-lane writes; switch request self-clears.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_sel_q <= oss_pkg::SEL_FRC_DIV;
      ctrl_div_q <= DIV_W'(oss_pkg::CT_DIV_RESET);
      pin_val_q  <= 1'b0;
      pin_oe_q   <= 1'b0;
      swreq_q    <= 1'b0;
    end else begin
      swreq_q <= wr_ct & wb_sel_i[1] & wb_dat_i[oss_pkg::CT_SWREQ];
      if (wr_ct && wb_sel_i[0]) begin
        ctrl_sel_q <= wb_dat_i[oss_pkg::CT_SEL_LSB +: 3];
      end
      if (wr_ct && wb_sel_i[2]) begin
        ctrl_div_q <= wb_dat_i[oss_pkg::CT_DIV_LSB +: DIV_W];
      end
      if (wr_ct && wb_sel_i[3]) begin
        pin_val_q <= wb_dat_i[oss_pkg::CT_PINV];
        pin_oe_q  <= wb_dat_i[oss_pkg::CT_PINOE];
      end
    end
  end

  // Edge counter for the fast RC divider.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      frc_prev_q <= 1'b0;
      frc_cnt_q  <= '0;
    end else begin
      frc_prev_q <= frc_s;
      if (frc_s != frc_prev_q) begin
        frc_cnt_q <= frc_cnt_q + CNT_W'(1);
      end
    end
  end

  // Processor, instruction and USB clocks.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sys_clk_q <= 1'b0;
      instr_q   <= 1'b0;
      usb_q     <= 1'b0;
      pll_q     <= 1'b0;
    end else begin
      sys_clk_q <= src_lvl;
      instr_q   <= instr_d;
      usb_q     <= pll_use & src_lvl;
      pll_q     <= pll_use;
    end
  end

  // Fail-safe idle counter and sticky failure flag.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      idle_q <= '0;
      fail_q <= 1'b0;
    end else begin
      if (src_edge || reload) begin
        idle_q <= '0;
      end else if (idle_q != IDLE_MAX) begin
        idle_q <= idle_q + IW'(1);
      end
      if (fail_go) begin
        fail_q <= 1'b1;
      end
    end
  end

  // Oscillator output pin drive.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_output_pin_q    <= 1'b0;
      osc_output_pin_oe_q <= 1'b0;
    end else begin
      osc_output_pin_q    <= osc_output_pin_d;
      osc_output_pin_oe_q <= osc_output_pin_oe_d;
    end
  end

  // Wishbone answer: one cycle after the request, unmapped reads zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_q <= 1'b0;
      wb_dat_q <= 32'h0000_0000;
    end else begin
      wb_ack_q <= acc;
      if (acc && !wb_we_i) begin
        wb_dat_q <= rd_word;
      end
    end
  end

  assign sys_clk_o           = sys_clk_q;
  assign instr_clk_o         = instr_q;
  assign usb_clk_o           = usb_q;
  assign pll_on_o            = pll_q;
  assign osc_output_pin_o    = osc_output_pin_q;
  assign osc_output_pin_oe_o = osc_output_pin_oe_q;
  assign wb_ack_o            = wb_ack_q;
  assign wb_dat_o            = wb_dat_q;

  // Checks on the selection and clock outputs.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_NO_RESERVED: assert property (
    cur_sel_q != oss_pkg::SEL_RSVD
  ) else $error("Reserved source selected.");

  AST_ERASED_START: assert property (
    load_q && cfg_word2_i == '1 |=> cur_sel_q == oss_pkg::SEL_FRC_DIV
      ##1 $stable(cur_sel_q)
  ) else $error("Erased device did not start on divided RC.");

  AST_INSTR_HALF: assert property (
    $changed(instr_clk_o) == $rose(sys_clk_o)
  ) else $error("Instruction clock not half processor clock.");

  AST_SWITCH_GATE: assert property (
    swreq_q && !sw_en && !load_q && !fail_go && !warm_go
      |=> $stable(cur_sel_q)
  ) else $error("Switch taken while switching disabled.");

  AST_FAIL_SAFE_CLOCK_MONITOR_GATE: assert property (
    !fail_safe_clock_monitor_en && !fail_q && !load_q |=> !fail_q
  ) else $error("Monitor acted while disabled.");

  AST_PLL_USB: assert property (
    pll_on_o |-> usb_clk_o == sys_clk_o
  ) else $error("USB clock does not follow PLL system clock.");

  AST_HOLD: assert property (
    !reload |=> $stable(cur_sel_q)
  ) else $error("Selection changed without cause.");

  AST_SEC_LOAD: assert property (
    load_q && cfg_word2_i[oss_pkg::FNOSC_LSB +: 3] == oss_pkg::SEL_SEC
      |=> cur_sel_q == oss_pkg::SEL_SEC
  ) else $error("Secondary select not taken at power-on.");

  AST_PIN_CLK: assert property (
    $past(pin_clk) && !$past(rst_i) |-> osc_output_pin_oe_o
      && osc_output_pin_o == instr_clk_o
  ) else $error("Pin does not carry instruction clock.");

  AST_DIV_PASS: assert property (
    cur_sel_q == oss_pkg::SEL_FRC_DIV && ctrl_div_q == '0
      |=> sys_clk_o == $past(frc_s)
  ) else $error("Undivided RC not passed through.");

  AST_FAIL_SAFE_CLOCK_MONITOR_PICK: assert property (
    fail_go |=> cur_sel_q == oss_pkg::SEL_FRC && fail_q
  ) else $error("Monitor trip did not fall back to fast RC.");

  AST_WARM_RELOAD: assert property (
    warm_reset_i && !sw_en && !load_q && !fail_go
      |=> cur_sel_q == $past(next_sel)
  ) else $error("Warm reset did not reload from configuration.");

  AST_SWITCH_TAKE: assert property (
    swap_go && !fail_go && ctrl_sel_q == oss_pkg::SEL_LOW_POWER_INTERNAL_RC
      |=> cur_sel_q == oss_pkg::SEL_LOW_POWER_INTERNAL_RC
  ) else $error("Permitted switch not taken.");

  COV_SWITCH: cover property (swap_go ##1 $changed(cur_sel_q));
  COV_FAIL: cover property (fail_go ##1 cur_sel_q == oss_pkg::SEL_FRC);
  COV_PLL: cover property ($rose(pll_on_o));
  COV_PIN: cover property (pin_clk ##2 $rose(osc_output_pin_o));

endmodule // oss_osc_select

//--- test/oss_osc_model.sv
// Behavioural oscillators seen at the block's source inputs.
module oss_osc_model #(
  parameter int HP_PRI  = 29,
  parameter int HP_SEC  = 31,
  parameter int HP_FRC  = 17,
  parameter int HP_LOW_POWER_INTERNAL_RC = 23
) (
  // Per-source run enables, bit order as the synchroniser vector.
  input  wire logic [3:0] run_i,
  // Oscillator levels.
  output logic            primary_osc_o = 1'b0,
  output logic            secondary_osc_o = 1'b0,
  output logic            fast_internal_rc_o = 1'b0,
  output logic            low_power_internal_rc_o = 1'b0
);
  timeunit 1ns;
  timeprecision 100ps;

  // A stopped source holds its level, as a dead crystal would.

  // Each source toggles at its own rate, slower than two system cycles.
  always #HP_PRI if (run_i[0]) primary_osc_o = ~primary_osc_o;
  always #HP_SEC if (run_i[1]) secondary_osc_o = ~secondary_osc_o;
  always #HP_FRC if (run_i[2]) fast_internal_rc_o = ~fast_internal_rc_o;
  always #HP_LOW_POWER_INTERNAL_RC if (run_i[3]) begin
    low_power_internal_rc_o = ~low_power_internal_rc_o;
  end
endmodule // oss_osc_model

//--- test/oscillator_source_select_tb_top.sv
// Self-checking bench for the oscillator source selection block.
module oscillator_source_select_tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int FSW = 16;
  logic                     clk_i = 1'b0;
  logic                     rst_i = 1'b1;
  logic [oss_pkg::CW_W-1:0] cfg = 24'hFFFFFF;
  logic                     warm = 1'b0;
  logic [3:0]               run = 4'hF;
  logic                     cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [3:0]               adr = 4'h0, sel = 4'h0;
  logic [31:0]              wdat = 32'h0;
  logic [31:0]              rd;
  wire                      sys, instr, usb, pll, pin, pin_oe, ack;
  wire                      pri, sec, fast_internal_rc, low_power_internal_rc;
  wire  [31:0]              rdat;
  int                       err_count = 0;
  int                       n_compared = 0;
  int                       bad, ts, ti, tp;
  logic [2:0] fn_t [12] = '{0, 1, 2, 2, 2, 3, 3, 4, 5, 6, 2, 3};
  logic [1:0] pm_t [12] = '{3, 3, 2, 1, 0, 1, 0, 3, 3, 0, 3, 2};
  logic [2:0] sl_t [12] = '{0, 1, 2, 2, 2, 3, 3, 4, 5, 7, 7, 7};

  // Design and oscillator model.
  oss_osc_select #(.FAIL_SAFE_CLOCK_MONITOR_WAIT(FSW)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .cfg_word2_i(cfg), .warm_reset_i(warm),
    .primary_osc_i(pri), .secondary_osc_i(sec), .fast_internal_rc_i(fast_internal_rc),
    .low_power_internal_rc_i(low_power_internal_rc), .sys_clk_o(sys), .instr_clk_o(instr),
    .usb_clk_o(usb), .pll_on_o(pll), .osc_output_pin_o(pin),
    .osc_output_pin_oe_o(pin_oe), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack));
  oss_osc_model i_osc (
    .run_i(run), .primary_osc_o(pri), .secondary_osc_o(sec),
    .fast_internal_rc_o(fast_internal_rc), .low_power_internal_rc_o(low_power_internal_rc));

  // 200 MHz system clock.
  always #2.5 clk_i = ~clk_i;

  // Builds configuration word 2 from its fields.
  function automatic logic [23:0] mk(logic [2:0] fn, logic [1:0] pm, ck,
                                     logic io);
    return {13'h0, fn, ck, io, 3'h0, pm};
  endfunction

  // Counts a comparison and reports a mismatch.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      err_count++;
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // One classic Wishbone cycle; read data is taken at the ack edge.
  task automatic wb(input logic w, input logic [3:0] a,
                    input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= s; wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_count++;
      finish_test();
    end else begin
      rd = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
    end
  endtask

  // Power-on reset with a given configuration word.
  task automatic boot(input logic [23:0] c);
    rst_i <= 1'b1; cfg <= c; run <= 4'hF;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask

  // Reads status and compares select, mode, flags and nominal rate.
  task automatic st(input logic [2:0] s, input logic [1:0] pm,
                    input logic sw, mon, pl, tr, input logic [7:0] mhz);
    wb(1'b0, oss_pkg::REG_STATUS, 32'h0, 4'hF);
    check(rd & 32'h00FF0F37, {8'h0, mhz, 4'h0, tr, pl, mon, sw, 2'h0, pm,
                              1'b0, s});
  endtask

  // Watches clock outputs; counts broken relations and toggles.
  task automatic watch(input int n);
    logic ps, pi, pp;
    ps = sys; pi = instr; pp = pin; bad = 0; ts = 0; ti = 0; tp = 0;
    repeat (n) begin
      @(posedge clk_i);
      if ((sys & !ps) != (instr != pi)) bad++;
      if (usb !== (pll ? sys : 1'b0)) bad++;
      ts += int'(sys & !ps);
      ti += int'(instr != pi);
      tp += int'(pin != pp);
      ps = sys; pi = instr; pp = pin;
    end
  endtask

  // A hang anywhere is cut short here.
  initial begin
    repeat (100000) @(posedge clk_i);
    err_count++;
    finish_test();
  end

  // Main sequence.
  initial begin
    boot(24'hFFFFFF);
    st(3'h7, 2'h3, 1'b0, 1'b0, 1'b0, 1'b0, 8'h04);
    wb(1'b0, oss_pkg::REG_CFG, 32'h0, 4'hF);
    check(rd, 32'h00FFFFFF);
    wb(1'b0, 4'hC, 32'h0, 4'hF);
    check(rd, 32'h0);
    wb(1'b0, 4'h2, 32'h0, 4'hF);
    check(rd, 32'h0);
    $display("erased start test done");
    for (int i = 0; i < 12; i++) begin
      boot(mk(fn_t[i], pm_t[i], 2'(i), 1'b0));
      st(sl_t[i], pm_t[i], ~2'(i) >> 1, 2'(i) == 2'h0,
         sl_t[i] inside {3'h1, 3'h3}, 1'b0,
         sl_t[i] == 3'h0 ? 8'h08 : sl_t[i] == 3'h7 ? 8'h04 :
         sl_t[i] inside {3'h1, 3'h3} ? 8'h60 : 8'h00);
      check({31'h0, pll}, {31'h0, sl_t[i] inside {3'h1, 3'h3}});
    end
    $display("selection table test done");
    boot(mk(3'h0, 2'h3, 2'h3, 1'b1));
    watch(400);
    check(bad, 0);
    check({31'h0, ts > 20}, 32'h1);
    check({31'h0, ti - tp <= 1 && tp - ti <= 1}, 32'h1);
    check({31'h0, pin_oe}, 32'h1);
    boot(mk(3'h1, 2'h3, 2'h3, 1'b0));
    watch(400);
    check(bad, 0);
    check({31'h0, ts > 20}, 32'h1);
    boot(mk(3'h0, 2'h3, 2'h3, 1'b0));
    wb(1'b1, oss_pkg::REG_CTRL, 32'h03000000, 4'h8);
    repeat (3) @(posedge clk_i);
    check({30'h0, pin_oe, pin}, 32'h3);
    boot(mk(3'h2, 2'h1, 2'h3, 1'b1));
    repeat (3) @(posedge clk_i);
    check({31'h0, pin_oe}, 32'h0);
    $display("clock and pin test done");
    boot(mk(3'h0, 2'h3, 2'h1, 1'b0));
    wb(1'b1, oss_pkg::REG_CTRL, 32'h00000105, 4'h3);
    st(3'h5, 2'h3, 1'b1, 1'b0, 1'b0, 1'b0, 8'h00);
    warm <= 1'b1;
    @(posedge clk_i);
    warm <= 1'b0;
    st(3'h5, 2'h3, 1'b1, 1'b0, 1'b0, 1'b0, 8'h00);
    wb(1'b1, oss_pkg::REG_CTRL, 32'h00030107, 4'hF);
    st(3'h7, 2'h3, 1'b1, 1'b0, 1'b0, 1'b0, 8'h01);
    wb(1'b0, oss_pkg::REG_CTRL, 32'h0, 4'hF);
    check(rd, 32'h00030007);
    wb(1'b1, oss_pkg::REG_CTRL, 32'h00000000, 4'h4);
    st(3'h7, 2'h3, 1'b1, 1'b0, 1'b0, 1'b0, 8'h08);
    boot(mk(3'h0, 2'h3, 2'h2, 1'b0));
    wb(1'b1, oss_pkg::REG_CTRL, 32'h00000105, 4'h3);
    st(3'h0, 2'h3, 1'b0, 1'b0, 1'b0, 1'b0, 8'h08);
    warm <= 1'b1;
    @(posedge clk_i);
    warm <= 1'b0;
    st(3'h0, 2'h3, 1'b0, 1'b0, 1'b0, 1'b0, 8'h08);
    $display("switching test done");
    boot(mk(3'h5, 2'h3, 2'h0, 1'b0));
    st(3'h5, 2'h3, 1'b1, 1'b1, 1'b0, 1'b0, 8'h00);
    run <= 4'h7;
    repeat (FSW + 24) @(posedge clk_i);
    st(3'h0, 2'h3, 1'b1, 1'b1, 1'b0, 1'b1, 8'h08);
    $display("fail-safe test done");
    finish_test();
  end
endmodule // oscillator_source_select_tb_top
